// ### airb_pkg.sv
// Package of the converter input, result and threshold register bank.
// Assumes a byte-wide register port with byte offsets as listed here.
package airb_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [5:0] OFS_CONTROL = 6'h00;
    localparam logic [5:0] OFS_INT_STATUS = 6'h01;
    localparam logic [5:0] OFS_INT_CLEAR = 6'h02;
    localparam logic [5:0] OFS_INT_ENABLE = 6'h03;
    localparam logic [5:0] OFS_POS_SEL = 6'h0c;
    localparam logic [5:0] OFS_NEG_SEL = 6'h0d;
    localparam logic [5:0] OFS_RESULT = 6'h10;
    localparam logic [5:0] OFS_SAMPLE = 6'h14;
    localparam logic [5:0] OFS_STAGING = 6'h18;
    localparam logic [5:0] OFS_WIN_LOW = 6'h1c;
    localparam logic [5:0] OFS_WIN_HIGH = 6'h1e;

    // ************************************************************
    // Field positions and codes
    // ************************************************************
    localparam int ROUTE_LSB = 6;
    localparam int CTL_DIFFERENTIAL_BIT = 0;
    localparam int CTL_GAIN_ON_BIT = 1;
    localparam int CTL_LOW_LATENCY_BIT = 2;
    localparam int EV_RESULT_BIT = 0;
    localparam int EV_SAMPLE_BIT = 1;
    localparam int EV_WIN_RES_BIT = 2;
    localparam int EV_WIN_SMP_BIT = 3;
    localparam int NUM_EVENTS = 4;
    localparam logic [1:0] ROUTE_DIRECT = 2'h0;
    localparam logic [1:0] ROUTE_GAIN_AMP = 2'h1;
    localparam logic [5:0] SEL_DEFAULT_GND = 6'h00;
    localparam logic [5:0] SEL_PIN_FIRST = 6'h01;
    localparam logic [5:0] SEL_POS_PIN_LAST = 6'h0f;
    localparam logic [5:0] SEL_NEG_PIN_LAST = 6'h07;
    localparam logic [5:0] SEL_GND = 6'h30;
    localparam logic [5:0] SEL_SUPPLY_DIV_TEN = 6'h31;
    localparam logic [5:0] SEL_TEMP_SENSOR = 6'h32;
    localparam logic [5:0] SEL_COMP_DAC_REF = 6'h33;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_ROUTE = 2'h0;
    localparam logic [5:0] RST_SEL = 6'h00;
    localparam logic [15:0] RST_THRESH = 16'h0000;
    localparam logic [31:0] RST_RESULT = 32'h0000_0000;
    localparam logic [15:0] RST_SAMPLE = 16'h0000;

endpackage

// ### airb_regs.sv
// Register bank for the converter input selectors, result, sample,
// shared byte staging and window thresholds, with a small interrupt block.
// Assumes the converter core delivers final results and samples as
// one-cycle strobes on MCLK, and software uses the byte-wide port.
//
// How it works
// - Routing code 0 feeds the inputs straight in, code 1 routes them through the amplifier, others select no path.
// - One shared routing field is written through either selector register and read back in both.
// - The positive selector decodes ground, pins 1 to 15, supply over ten, temperature sensor and comparator reference.
// - The negative selector decodes ground, pins 1 to 7, supply over ten and comparator reference only.
// - The 32-bit result is read-only with byte n at the base offset plus n.
// - The 16-bit sample is read-only with its low byte at the base and high byte at base plus one.
// - Three shared byte staging registers are readable, writable and reset to zero.
// - A writable 16-bit low threshold is used when checking the result or the sample.
// - A writable 16-bit high threshold is used when checking the result or the sample.
// - Each threshold is a byte pair with the low byte at the base offset.
// - Only the final result after accumulation and scaling, and each valid sample, are checked against the window.
// - Single-ended conversions use only the positive selector; differential ones use both.
// - The amplifier is powered when enabled and routed, or continuously when low latency is also set.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps

module airb_regs #(
    parameter int ADDR_W = 6
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST_N,
    // Register port.
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Converter core side.
    input wire logic [31:0] RESULT_IN,
    input wire logic RESULT_FINAL,
    input wire logic [15:0] SAMPLE_IN,
    input wire logic SAMPLE_VALID,
    // Analog front end steering.
    output logic [5:0] POS_SEL,
    output logic POS_SEL_OK,
    output logic [5:0] NEG_SEL,
    output logic NEG_SEL_OK,
    output logic NEG_IN_USE,
    output logic ROUTE_DIRECT_EN,
    output logic ROUTE_GAIN_EN,
    output logic GAIN_AMP_PWR,
    // Interrupt.
    output logic IRQ
);

    // ************************************************************
    // Elaboration check and decode helpers
    // ************************************************************
    if (ADDR_W < 6) begin : g_addr_check
        $error("ADDR_W must be at least 6 to reach every register");
    end

    // Selector decode shared by both inputs; only the pin range and the temperature sensor code differ.
    function automatic logic sel_ok(input logic [5:0] code, input logic [5:0] pin_last,
                                    input logic temp_ok);
        logic ok;
        ok = 1'b0;
        if (code == airb_pkg::SEL_DEFAULT_GND || code == airb_pkg::SEL_GND) begin
            ok = 1'b1;
        end else if (code >= airb_pkg::SEL_PIN_FIRST && code <= pin_last) begin
            ok = 1'b1;
        end else if (code == airb_pkg::SEL_SUPPLY_DIV_TEN) begin
            ok = 1'b1;
        end else if (code == airb_pkg::SEL_TEMP_SENSOR) begin
            ok = temp_ok;
        end else if (code == airb_pkg::SEL_COMP_DAC_REF) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    // Address match helper used by every write decode and by the staging snapshot on reads.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [2:0] control_q;
    logic [1:0] route_q;
    logic [5:0] pos_sel_q;
    logic [5:0] neg_sel_q;
    logic [31:0] result_q;
    logic [15:0] sample_q;
    logic [7:0] staging_q [3];
    logic [15:0] win_low_q;
    logic [15:0] win_high_q;
    logic [airb_pkg::NUM_EVENTS-1:0] int_status_q;
    logic [airb_pkg::NUM_EVENTS-1:0] int_enable_q;
    logic [airb_pkg::NUM_EVENTS-1:0] events;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic res_outside;
    logic smp_outside;

    // ************************************************************
    // Control and selector registers
    // ************************************************************
    // Control bits for differential mode, amplifier enable and low latency.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            control_q <= 3'h0;
        end else if (WR && hit(ADDR, airb_pkg::OFS_CONTROL)) begin
            control_q <= WDATA[2:0];
        end
    end

    // One routing field behind both selector registers.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            route_q <= airb_pkg::RST_ROUTE;
        end else if (WR && (hit(ADDR, airb_pkg::OFS_POS_SEL) ||
                            hit(ADDR, airb_pkg::OFS_NEG_SEL))) begin
            route_q <= WDATA[airb_pkg::ROUTE_LSB +: 2];
        end
    end

    // Selector codes are stored as written, reserved ones included.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pos_sel_q <= airb_pkg::RST_SEL;
            neg_sel_q <= airb_pkg::RST_SEL;
        end else if (WR && hit(ADDR, airb_pkg::OFS_POS_SEL)) begin
            pos_sel_q <= WDATA[5:0];
        end else if (WR && hit(ADDR, airb_pkg::OFS_NEG_SEL)) begin
            neg_sel_q <= WDATA[5:0];
        end
    end

    // ************************************************************
    // Front end steering
    // ************************************************************
    // A reserved selector or routing code drives no path at all.
    assign POS_SEL = pos_sel_q;
    assign NEG_SEL = neg_sel_q;
    assign POS_SEL_OK = sel_ok(pos_sel_q, airb_pkg::SEL_POS_PIN_LAST, 1'b1);
    assign NEG_SEL_OK = sel_ok(neg_sel_q, airb_pkg::SEL_NEG_PIN_LAST, 1'b0);
    assign NEG_IN_USE = control_q[airb_pkg::CTL_DIFFERENTIAL_BIT];
    assign ROUTE_DIRECT_EN = route_q == airb_pkg::ROUTE_DIRECT;
    assign ROUTE_GAIN_EN = route_q == airb_pkg::ROUTE_GAIN_AMP;
    // Low latency keeps the amplifier settled so a later switch costs no start-up time.
    assign GAIN_AMP_PWR = control_q[airb_pkg::CTL_GAIN_ON_BIT] &&
                          (ROUTE_GAIN_EN || control_q[airb_pkg::CTL_LOW_LATENCY_BIT]);

    // ************************************************************
    // Result and sample capture
    // ************************************************************
    // Partial sums never reach the register; only the final strobe loads it.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            result_q <= airb_pkg::RST_RESULT;
        end else if (RESULT_FINAL) begin
            result_q <= RESULT_IN;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sample_q <= airb_pkg::RST_SAMPLE;
        end else if (SAMPLE_VALID) begin
            sample_q <= SAMPLE_IN;
        end
    end

    // ************************************************************
    // Window thresholds
    // ************************************************************
    // The high byte waits in staging so the core never sees half a threshold.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            win_low_q <= airb_pkg::RST_THRESH;
            win_high_q <= airb_pkg::RST_THRESH;
        end else if (WR && hit(ADDR, airb_pkg::OFS_WIN_LOW)) begin
            win_low_q <= {staging_q[0], WDATA};
        end else if (WR && hit(ADDR, airb_pkg::OFS_WIN_HIGH)) begin
            win_high_q <= {staging_q[0], WDATA};
        end
    end

    // Checks use the incoming final value so the event lines up with the load.
    // Thresholds are taken as unsigned in whatever format software chose.
    assign res_outside = RESULT_IN < {16'h0000, win_low_q} ||
                         RESULT_IN > {16'h0000, win_high_q};
    assign smp_outside = SAMPLE_IN < win_low_q || SAMPLE_IN > win_high_q;

    // ************************************************************
    // Byte staging
    // ************************************************************
    // Low-byte reads snapshot upper bytes, upper-byte writes park here.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            for (int i = 0; i < 3; i++) begin
                staging_q[i] <= airb_pkg::RST_BYTE;
            end
        end else if (RD && hit(ADDR, airb_pkg::OFS_RESULT)) begin
            staging_q[0] <= result_q[15:8];
            staging_q[1] <= result_q[23:16];
            staging_q[2] <= result_q[31:24];
        end else if (RD && hit(ADDR, airb_pkg::OFS_SAMPLE)) begin
            staging_q[0] <= sample_q[15:8];
        end else if (RD && hit(ADDR, airb_pkg::OFS_WIN_LOW)) begin
            staging_q[0] <= win_low_q[15:8];
        end else if (RD && hit(ADDR, airb_pkg::OFS_WIN_HIGH)) begin
            staging_q[0] <= win_high_q[15:8];
        end else if (WR) begin
            for (int i = 0; i < 3; i++) begin
                if (hit(ADDR, 6'(airb_pkg::OFS_STAGING + i))) begin
                    staging_q[i] <= WDATA;
                end
            end
            if (hit(ADDR, 6'(airb_pkg::OFS_WIN_LOW + 1)) ||
                hit(ADDR, 6'(airb_pkg::OFS_WIN_HIGH + 1))) begin
                staging_q[0] <= WDATA;
            end
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign events[airb_pkg::EV_RESULT_BIT] = RESULT_FINAL;
    assign events[airb_pkg::EV_SAMPLE_BIT] = SAMPLE_VALID;
    assign events[airb_pkg::EV_WIN_RES_BIT] = RESULT_FINAL && res_outside;
    assign events[airb_pkg::EV_WIN_SMP_BIT] = SAMPLE_VALID && smp_outside;

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            int_status_q <= '0;
        end else if (WR && hit(ADDR, airb_pkg::OFS_INT_CLEAR)) begin
            int_status_q <= (int_status_q & ~WDATA[airb_pkg::NUM_EVENTS-1:0]) | events;
        end else begin
            int_status_q <= int_status_q | events;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            int_enable_q <= '0;
        end else if (WR && hit(ADDR, airb_pkg::OFS_INT_ENABLE)) begin
            int_enable_q <= WDATA[airb_pkg::NUM_EVENTS-1:0];
        end
    end

    assign IRQ = |(int_status_q & int_enable_q);

    // ************************************************************
    // Read data
    // ************************************************************
    // Upper bytes of wide registers come from staging, which is what keeps
    // a byte-by-byte read coherent while the core keeps updating.
    always_comb begin
        rdata_d = 8'h00;
        case (ADDR[5:0])
            airb_pkg::OFS_CONTROL: rdata_d = {5'h00, control_q};
            airb_pkg::OFS_INT_STATUS: rdata_d = {4'h0, int_status_q};
            airb_pkg::OFS_INT_ENABLE: rdata_d = {4'h0, int_enable_q};
            airb_pkg::OFS_POS_SEL: rdata_d = {route_q, pos_sel_q};
            airb_pkg::OFS_NEG_SEL: rdata_d = {route_q, neg_sel_q};
            airb_pkg::OFS_RESULT: rdata_d = result_q[7:0];
            6'(airb_pkg::OFS_RESULT + 1): rdata_d = staging_q[0];
            6'(airb_pkg::OFS_RESULT + 2): rdata_d = staging_q[1];
            6'(airb_pkg::OFS_RESULT + 3): rdata_d = staging_q[2];
            airb_pkg::OFS_SAMPLE: rdata_d = sample_q[7:0];
            6'(airb_pkg::OFS_SAMPLE + 1): rdata_d = staging_q[0];
            airb_pkg::OFS_STAGING: rdata_d = staging_q[0];
            6'(airb_pkg::OFS_STAGING + 1): rdata_d = staging_q[1];
            6'(airb_pkg::OFS_STAGING + 2): rdata_d = staging_q[2];
            airb_pkg::OFS_WIN_LOW: rdata_d = win_low_q[7:0];
            6'(airb_pkg::OFS_WIN_LOW + 1): rdata_d = staging_q[0];
            airb_pkg::OFS_WIN_HIGH: rdata_d = win_high_q[7:0];
            6'(airb_pkg::OFS_WIN_HIGH + 1): rdata_d = staging_q[0];
            default: rdata_d = 8'h00;
        endcase
        if (ADDR_W > 6 && (ADDR >> 6) != '0) begin
            rdata_d = 8'h00;
        end
    end

    // Data stands only in the cycle after the read strobe.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else if (RD) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign RDATA = rdata_q;

endmodule

// ### airb_regs_sva.sv
// Checker for the converter register bank, watching only its ports.
// Assumes it is bound to every airb_regs instance on one clock.
`timescale 1ns/100ps

module airb_regs_chk #(
    parameter int ADDR_W = 6
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST_N,
    // Register port.
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Core side.
    input wire logic [31:0] RESULT_IN,
    input wire logic RESULT_FINAL,
    input wire logic [15:0] SAMPLE_IN,
    input wire logic SAMPLE_VALID,
    // Steering and interrupt.
    input wire logic [5:0] POS_SEL,
    input wire logic POS_SEL_OK,
    input wire logic [5:0] NEG_SEL,
    input wire logic NEG_SEL_OK,
    input wire logic NEG_IN_USE,
    input wire logic ROUTE_DIRECT_EN,
    input wire logic ROUTE_GAIN_EN,
    input wire logic GAIN_AMP_PWR,
    input wire logic IRQ
);
    // ************************************************************
    // Shadow state
    // ************************************************************
    logic [7:0] wdata_q;
    logic [2:0] ctl_q;
    logic [31:0] res_q;
    logic [15:0] smp_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    // Shadows kept apart from the design so a stuck register shows up.
    always_ff @(posedge MCLK) begin
        wdata_q <= WDATA;
        if (!RST_N) begin
            ctl_q <= 3'h0;
            res_q <= 32'h0000_0000;
            smp_q <= 16'h0000;
        end else begin
            if (WR && ADDR == airb_pkg::OFS_CONTROL) ctl_q <= WDATA[2:0];
            if (RESULT_FINAL) res_q <= RESULT_IN;
            if (SAMPLE_VALID) smp_q <= SAMPLE_IN;
        end
    end

    function automatic logic pos_ok(input logic [5:0] c);
        return (c <= 6'h0f) || (c >= 6'h30 && c <= 6'h33);
    endfunction

    function automatic logic neg_ok(input logic [5:0] c);
        return (c <= 6'h07) || c == 6'h30 || c == 6'h31 || c == 6'h33;
    endfunction

    // ************************************************************
    // Assertions
    // ************************************************************
    route_shared_a:
    assert property (WR && (ADDR == airb_pkg::OFS_POS_SEL || ADDR == airb_pkg::OFS_NEG_SEL)
        |=> ROUTE_GAIN_EN == (wdata_q[7:6] == 2'h1) && ROUTE_DIRECT_EN == (wdata_q[7:6] == 2'h0))
        else $error("route outputs do not follow the written routing code");
    pos_write_a:
    assert property (WR && ADDR == airb_pkg::OFS_POS_SEL |=> POS_SEL == wdata_q[5:0])
        else $error("positive selector not updated by its write");
    neg_write_a:
    assert property (WR && ADDR == airb_pkg::OFS_NEG_SEL |=> NEG_SEL == wdata_q[5:0] && $stable(POS_SEL))
        else $error("negative selector write wrong or disturbed the positive one");
    pos_legal_a:
    assert property (POS_SEL_OK == pos_ok(POS_SEL)) else $error("positive code legality wrong");
    neg_legal_a:
    assert property (NEG_SEL_OK == neg_ok(NEG_SEL)) else $error("negative code legality wrong");
    result_read_a:
    assert property (RD && ADDR == airb_pkg::OFS_RESULT && !RESULT_FINAL |=> RDATA == res_q[7:0])
        else $error("result low byte read wrong");
    sample_read_a:
    assert property (RD && ADDR == airb_pkg::OFS_SAMPLE && !SAMPLE_VALID |=> RDATA == smp_q[7:0])
        else $error("sample low byte read wrong");
    differential_use_a:
    assert property (NEG_IN_USE == ctl_q[0]) else $error("negative input use wrong");
    amp_power_a:
    assert property (GAIN_AMP_PWR == (ctl_q[1] && (ROUTE_GAIN_EN || ctl_q[2])))
        else $error("amplifier power wrong");

    // Main scenarios that the bench must reach.
    cover property (WR && ADDR == airb_pkg::OFS_NEG_SEL && WDATA[7:6] == 2'h1);
    cover property (GAIN_AMP_PWR && !ROUTE_GAIN_EN);
    cover property (IRQ);
endmodule

bind airb_regs airb_regs_chk #(.ADDR_W(ADDR_W)) i_chk (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RESULT_IN(RESULT_IN),
    .RESULT_FINAL(RESULT_FINAL), .SAMPLE_IN(SAMPLE_IN), .SAMPLE_VALID(SAMPLE_VALID),
    .POS_SEL(POS_SEL), .POS_SEL_OK(POS_SEL_OK), .NEG_SEL(NEG_SEL), .NEG_SEL_OK(NEG_SEL_OK),
    .NEG_IN_USE(NEG_IN_USE), .ROUTE_DIRECT_EN(ROUTE_DIRECT_EN), .ROUTE_GAIN_EN(ROUTE_GAIN_EN),
    .GAIN_AMP_PWR(GAIN_AMP_PWR), .IRQ(IRQ));

// ### airb_regs_test.sv
// Self-checking bench for the converter register bank.
// Assumes airb_regs with its bound checker; the bench drives every port.
`timescale 1ns/100ps

module airb_regs_test;
    typedef struct {logic [5:0] a; logic [7:0] d;} airb_exp_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic res_fin = 1'b0;
    logic smp_val = 1'b0;
    logic rd_d = 1'b0;
    logic [31:0] res_in = 32'h0000_0000;
    logic [15:0] smp_in = 16'h0000;
    logic [7:0] rdata;
    logic [5:0] pos_sel, neg_sel;
    logic pos_ok, neg_ok, neg_use, rt_dir, rt_gain, amp_pwr, irq;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    airb_exp_t exp_q[$];
    logic [5:0] rst_a[16] = '{6'h0c, 6'h0d, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15,
        6'h18, 6'h19, 6'h1a, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h3f};
    logic [5:0] codes[12] = '{6'h00, 6'h01, 6'h07, 6'h08, 6'h0f, 6'h10, 6'h30, 6'h31,
        6'h32, 6'h33, 6'h34, 6'h3f};

    // Free-running 200 MHz clock.
    always #2.5 mclk = ~mclk;

    airb_regs i_dut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RESULT_IN(res_in), .RESULT_FINAL(res_fin), .SAMPLE_IN(smp_in),
        .SAMPLE_VALID(smp_val), .POS_SEL(pos_sel), .POS_SEL_OK(pos_ok), .NEG_SEL(neg_sel),
        .NEG_SEL_OK(neg_ok), .NEG_IN_USE(neg_use), .ROUTE_DIRECT_EN(rt_dir),
        .ROUTE_GAIN_EN(rt_gain), .GAIN_AMP_PWR(amp_pwr), .IRQ(irq));

    // ************************************************************
    // Driver and comparison tasks
    // ************************************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %0s expected %h seen %h", n, e, g);
        end
    endtask

    // Strobes are left high so back-to-back cycles never assign twice in one step.
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
    endtask

    task automatic rdx(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back('{a, e});
        bus(1'b0, a, 8'h00);
    endtask

    task automatic core(input logic [31:0] r, input logic [15:0] s, input logic sv);
        wr <= 1'b0;
        rd <= 1'b0;
        res_in <= r;
        smp_in <= s;
        res_fin <= 1'b1;
        smp_val <= sv;
        @(posedge mclk);
    endtask

    // Two quiet edges, so level outputs have settled before they are looked at.
    task automatic idle();
        wr <= 1'b0;
        rd <= 1'b0;
        res_fin <= 1'b0;
        smp_val <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic done(input string n);
        $display("test %0s finished", n);
    endtask

    function automatic logic legal(input logic [5:0] c, input logic p);
        return c <= (p ? 6'h0f : 6'h07) || c == 6'h30 || c == 6'h31 || c == 6'h33
            || (p && c == 6'h32);
    endfunction

    task automatic end_of_test();
        // A read whose data never came back is a mismatch too.
        if (exp_q.size() != 0) begin
            num_errors++;
        end
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe, so compare them there.
    always @(posedge mclk) begin
        airb_exp_t e;
        rd_d <= rd;
        if (rd_d && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk($sformatf("rdata_%h", e.a), e.d, rdata);
        end
    end

    // Hang guard, far above the few hundred cycles the run needs.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [1:0] r, r2;
        logic [31:0] res;
        logic [15:0] smp;
        logic [7:0] v;
        int k;
        k = $urandom(9);
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rst_a[i]) rdx(rst_a[i], 8'h00);
        idle();
        chk("route_direct", 1'b1, rt_dir);
        done("reset");
        foreach (codes[i]) begin
            r = 2'($urandom_range(3));
            r2 = 2'($urandom_range(3));
            bus(1'b1, airb_pkg::OFS_POS_SEL, {r, codes[i]});
            bus(1'b1, airb_pkg::OFS_NEG_SEL, {r2, codes[i]});
            idle();
            chk("pos_ok", legal(codes[i], 1'b1), pos_ok);
            chk("neg_ok", legal(codes[i], 1'b0), neg_ok);
            chk("pos_sel", codes[i], pos_sel);
            chk("neg_sel", codes[i], neg_sel);
            chk("route_gain", r2 == 2'h1, rt_gain);
            chk("route_direct", r2 == 2'h0, rt_dir);
            rdx(airb_pkg::OFS_POS_SEL, {r2, codes[i]});
            rdx(airb_pkg::OFS_NEG_SEL, {r2, codes[i]});
            idle();
        end
        done("selectors");
        for (k = 0; k < 24; k++) begin
            bus(1'b1, airb_pkg::OFS_CONTROL, 8'(k % 8));
            bus(1'b1, airb_pkg::OFS_NEG_SEL, {2'(k / 8), 6'h01});
            idle();
            chk("amp_pwr", k[1] && (k / 8 == 1 || k[2]), amp_pwr);
            chk("neg_use", k[0], neg_use);
        end
        done("control");
        res = $urandom();
        smp = 16'($urandom());
        core(res, smp, 1'b1);
        res_fin <= 1'b0;
        smp_val <= 1'b0;
        bus(1'b1, airb_pkg::OFS_RESULT, ~res[7:0]);
        rdx(airb_pkg::OFS_RESULT, res[7:0]);
        for (k = 1; k < 4; k++) rdx(6'(airb_pkg::OFS_STAGING + k - 1), res[8*k +: 8]);
        for (k = 1; k < 4; k++) rdx(6'(airb_pkg::OFS_RESULT + k), res[8*k +: 8]);
        rdx(airb_pkg::OFS_SAMPLE, smp[7:0]);
        rdx(6'(airb_pkg::OFS_SAMPLE + 1), smp[15:8]);
        v = 8'($urandom());
        bus(1'b1, 6'(airb_pkg::OFS_STAGING + 2), v);
        rdx(6'(airb_pkg::OFS_STAGING + 2), v);
        bus(1'b1, 6'(airb_pkg::OFS_WIN_LOW + 1), 8'h01);
        bus(1'b1, airb_pkg::OFS_WIN_LOW, 8'h00);
        bus(1'b1, 6'(airb_pkg::OFS_WIN_HIGH + 1), 8'h02);
        bus(1'b1, airb_pkg::OFS_WIN_HIGH, 8'h00);
        rdx(airb_pkg::OFS_WIN_LOW, 8'h00);
        rdx(6'(airb_pkg::OFS_WIN_LOW + 1), 8'h01);
        rdx(airb_pkg::OFS_WIN_HIGH, 8'h00);
        rdx(6'(airb_pkg::OFS_WIN_HIGH + 1), 8'h02);
        done("data");
        bus(1'b1, airb_pkg::OFS_INT_ENABLE, 8'h0f);
        bus(1'b1, airb_pkg::OFS_INT_CLEAR, 8'h0f);
        idle();
        chk("irq", 1'b0, irq);
        core(32'h0000_0100, 16'h0000, 1'b0);
        idle();
        rdx(airb_pkg::OFS_INT_STATUS, 8'h01);
        chk("irq", 1'b1, irq);
        core(32'h0000_0201, 16'h00ff, 1'b1);
        idle();
        rdx(airb_pkg::OFS_INT_STATUS, 8'h0f);
        bus(1'b1, airb_pkg::OFS_INT_CLEAR, 8'h0f);
        bus(1'b1, airb_pkg::OFS_INT_ENABLE, 8'h00);
        core(32'h0000_0200, 16'h0000, 1'b0);
        idle();
        rdx(airb_pkg::OFS_INT_STATUS, 8'h01);
        idle();
        chk("irq", 1'b0, irq);
        done("window");
        end_of_test();
    end
endmodule
